//--- common/pee_pkg.sv
// Package for the parallel EEPROM host controller: pin widths, timing, commands.
// Assumes a 100 MHz system clock; no registers are reachable by software.
package pee_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_LSB = 6; // Offset bits below the page address
  localparam int CLK_PERIOD_NS = 10;
  // Byte load window and self-timed program period
  localparam int LOAD_WINDOW_NS = 100000;
  localparam int LOAD_GAP_NS = 50000; // Safe spacing, well inside the window
  localparam int LOAD_GAP_CYC = (LOAD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_PERIOD_NS = 2000000;
  localparam int PROGRAM_PERIOD_CYC = PROGRAM_PERIOD_NS / CLK_PERIOD_NS;
  // Bus phase counter loads; each phase lasts one cycle more
  localparam int SETUP_CYC = 2;
  localparam int STROBE_CYC = 4;
  localparam int READ_CYC = 8;
  localparam int POLL_LIMIT = 1000000;
  // Arming and disarming command writes: address, data pairs
  localparam logic [12:0] CMD_ADDR0 = 13'h1555;
  localparam logic [12:0] CMD_ADDR1 = 13'h0AAA;
  localparam logic [7:0] CMD_DATA0 = 8'hAA;
  localparam logic [7:0] CMD_DATA1 = 8'h55;
  localparam logic [7:0] CMD_ARM = 8'hA0;
  localparam logic [7:0] CMD_DIS0 = 8'h80;
  localparam logic [7:0] CMD_DIS1 = 8'h20;
  // Host request kinds
  typedef enum logic [1:0] {
    PEE_OP_READ, PEE_OP_WRITE, PEE_OP_ARM, PEE_OP_DISARM
  } pee_op_t;
endpackage : pee_pkg

//--- verilog/pee_bus_cycle.sv
// One pin cycle on the parallel bus: read or write strobe sequence.
// Assumes a single clock; pin inputs arrive unsynchronised from the device.
`timescale 1ns/10ps
module pee_bus_cycle (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the sequencer
  input wire logic go,
  input wire logic is_write,
  input wire logic [12:0] addr,
  input wire logic [7:0] wdata,
  // Completion
  output logic done,
  output logic [7:0] rdata,
  // Device pins
  output logic [12:0] word_select_lines,
  output logic [7:0] byte_lines_o,
  output logic byte_lines_oe,
  input wire logic [7:0] byte_lines_i,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic wr_strobe_n
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} pee_cyc_st_t;
  typedef struct packed {
    pee_cyc_st_t st;
    logic [3:0] cnt;
    logic wr;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic done;
    logic [7:0] rdata;
    logic [12:0] a;
    logic [7:0] d;
    logic oe;
    logic cs_n;
    logic og_n;
    logic we_n;
  } pee_cyc_t;
  pee_cyc_t cur_ff, nxt_ff;

  // Sequencing of select, gate and strobe
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.sync1 = byte_lines_i;
    nxt_ff.sync2 = cur_ff.sync1;
    nxt_ff.done = 1'b0;
    case (cur_ff.st)
      S_IDLE: begin
        if (go) begin
          nxt_ff.a = addr;
          nxt_ff.d = wdata;
          nxt_ff.wr = is_write;
          nxt_ff.oe = is_write;
          nxt_ff.og_n = 1'b1;
          nxt_ff.cs_n = 1'b0;
          nxt_ff.cnt = 4'(pee_pkg::SETUP_CYC);
          nxt_ff.st = S_SETUP;
        end
      end
      S_SETUP: begin
        if (cur_ff.cnt != 4'h0) begin
          nxt_ff.cnt = cur_ff.cnt - 4'h1;
        end else begin
          // Gate stays high during writes, so a write is never a read
          if (cur_ff.wr) begin
            nxt_ff.we_n = 1'b0;
            nxt_ff.cnt = 4'(pee_pkg::STROBE_CYC);
          end else begin
            nxt_ff.og_n = 1'b0;
            nxt_ff.cnt = 4'(pee_pkg::READ_CYC);
          end
          nxt_ff.st = S_STROBE;
        end
      end
      S_STROBE: begin
        if (cur_ff.cnt != 4'h0) begin
          nxt_ff.cnt = cur_ff.cnt - 4'h1;
        end else begin
          // Data held past the strobe's rising edge
          nxt_ff.we_n = 1'b1;
          nxt_ff.og_n = 1'b1;
          nxt_ff.rdata = cur_ff.sync2;
          nxt_ff.st = S_HOLD;
        end
      end
      S_HOLD: begin
        nxt_ff.cs_n = 1'b1;
        nxt_ff.oe = 1'b0;
        nxt_ff.done = 1'b1;
        nxt_ff.st = S_IDLE;
      end
      default: nxt_ff.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{st: S_IDLE, cnt: 4'h0, wr: 1'b0, sync1: 8'h00, sync2: 8'h00,
                  done: 1'b0, rdata: 8'h00, a: 13'h0000, d: 8'h00, oe: 1'b0,
                  cs_n: 1'b1, og_n: 1'b1, we_n: 1'b1};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign done = cur_ff.done;
  assign rdata = cur_ff.rdata;
  assign word_select_lines = cur_ff.a;
  assign byte_lines_o = cur_ff.d;
  assign byte_lines_oe = cur_ff.oe;
  assign chip_sel_n = cur_ff.cs_n;
  assign out_gate_n = cur_ff.og_n;
  assign wr_strobe_n = cur_ff.we_n;
endmodule : pee_bus_cycle

//--- verilog/pee_host.sv
// Host controller for a byte-alterable parallel EEPROM with write protection.
// Assumes the device on its pins and a user port on the same clock.
`timescale 1ns/10ps
module pee_host #(
  parameter int PAGE_BYTES = pee_pkg::PAGE_BYTES,
  parameter int LOAD_GAP_CYC = pee_pkg::LOAD_GAP_CYC,
  parameter int POLL_LIMIT = pee_pkg::POLL_LIMIT,
  parameter logic [12:0] CMD_ADDR0 = pee_pkg::CMD_ADDR0,
  parameter logic [12:0] CMD_ADDR1 = pee_pkg::CMD_ADDR1,
  parameter logic [7:0] CMD_DATA0 = pee_pkg::CMD_DATA0,
  parameter logic [7:0] CMD_DATA1 = pee_pkg::CMD_DATA1,
  parameter logic [7:0] CMD_ARM = pee_pkg::CMD_ARM,
  parameter logic [7:0] CMD_DIS0 = pee_pkg::CMD_DIS0,
  parameter logic [7:0] CMD_DIS1 = pee_pkg::CMD_DIS1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User request
  input wire logic req_valid,
  input wire pee_pkg::pee_op_t req_op,
  input wire logic [12:0] req_addr,
  input wire logic [6:0] req_len_m1,
  input wire logic protected_mode,
  // Page data feed, one byte per accepted beat
  input wire logic [7:0] wr_data,
  output logic wr_data_take,
  // User answer
  output logic busy,
  output logic done,
  output logic timeout,
  output logic [7:0] rd_data,
  // Device pins
  output logic [12:0] word_select_lines,
  output logic [7:0] byte_lines_o,
  output logic byte_lines_oe,
  input wire logic [7:0] byte_lines_i,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic wr_strobe_n
);
  // Elaboration checks: the offset wrap is six bits, the counter 21 bits, and a
  // gap plus one bus cycle must still fit the byte load window
  if (PAGE_BYTES != pee_pkg::PAGE_BYTES) begin : g_bad_page
    $error("PAGE_BYTES must match the six-bit page offset");
  end
  if (LOAD_GAP_CYC < 1 ||
      LOAD_GAP_CYC + 32 >= pee_pkg::LOAD_WINDOW_NS / pee_pkg::CLK_PERIOD_NS) begin : g_bad_gap
    $error("LOAD_GAP_CYC must stay inside the load window");
  end
  if (POLL_LIMIT < 1 || POLL_LIMIT >= (1 << 21)) begin : g_bad_poll
    $error("POLL_LIMIT must fit the 21-bit counter");
  end

  typedef enum logic [2:0] {
    H_IDLE, H_CMD, H_DATA, H_GAP, H_POLL, H_FIN
  } pee_host_st_t;
  typedef struct packed {
    pee_host_st_t st;
    pee_pkg::pee_op_t op;
    logic [2:0] step;
    logic [6:0] left;
    logic [12:0] addr;
    logic [7:0] last;
    logic [20:0] cnt;
    logic go;
    logic take;
    logic busy;
    logic done;
    logic tmo;
    logic [7:0] rd;
    logic have_prev;
    logic prev6;
  } pee_host_s_t;
  pee_host_s_t cur_ff, nxt_ff;

  logic cyc_done;
  logic [7:0] cyc_rdata;
  logic [12:0] cyc_addr;
  logic [7:0] cyc_data;
  logic cyc_wr;

  // Command table: three for arming writes, six for disarming
  function automatic logic [20:0] cmd_word(input logic [2:0] i, input logic dis);
    logic [20:0] w;
    w = {CMD_ADDR0, CMD_DATA0};
    case (i)
      3'h0, 3'h3: w = {CMD_ADDR0, CMD_DATA0};
      3'h1, 3'h4: w = {CMD_ADDR1, CMD_DATA1};
      3'h2: w = {CMD_ADDR0, dis ? CMD_DIS0 : CMD_ARM};
      3'h5: w = {CMD_ADDR0, CMD_DIS1};
      default: w = {CMD_ADDR0, CMD_DATA0};
    endcase
    return w;
  endfunction : cmd_word

  // Bus cycle request drawn from the host state
  always_comb begin
    cyc_wr = 1'b1;
    cyc_addr = cur_ff.addr;
    cyc_data = wr_data;
    if (cur_ff.st == H_CMD) begin
      {cyc_addr, cyc_data} = cmd_word(cur_ff.step, cur_ff.op == pee_pkg::PEE_OP_DISARM);
    end else if (cur_ff.st == H_POLL || cur_ff.op == pee_pkg::PEE_OP_READ) begin
      cyc_wr = 1'b0;
    end
  end

  pee_bus_cycle u_cycle (
    .clk(clk), .rst(rst), .go(cur_ff.go), .is_write(cyc_wr), .addr(cyc_addr),
    .wdata(cyc_data), .done(cyc_done), .rdata(cyc_rdata),
    .word_select_lines(word_select_lines), .byte_lines_o(byte_lines_o),
    .byte_lines_oe(byte_lines_oe), .byte_lines_i(byte_lines_i),
    .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n)
  );

  // Operation sequencer
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.go = 1'b0;
    nxt_ff.take = 1'b0;
    nxt_ff.done = 1'b0;
    case (cur_ff.st)
      H_IDLE: begin
        if (req_valid) begin
          nxt_ff.op = req_op;
          nxt_ff.addr = req_addr;
          nxt_ff.left = req_len_m1;
          nxt_ff.step = 3'h0;
          nxt_ff.busy = 1'b1;
          nxt_ff.tmo = 1'b0;
          nxt_ff.have_prev = 1'b0;
          nxt_ff.go = 1'b1;
          // Arm, disarm, and protected writes lead with commands
          if (req_op == pee_pkg::PEE_OP_ARM || req_op == pee_pkg::PEE_OP_DISARM ||
              (req_op == pee_pkg::PEE_OP_WRITE && protected_mode)) begin
            nxt_ff.st = H_CMD;
          end else begin
            nxt_ff.st = H_DATA;
          end
        end
      end
      H_CMD: begin
        // Back to back, never interleaved with other writes
        if (cyc_done) begin
          nxt_ff.step = cur_ff.step + 3'h1;
          if (cur_ff.op == pee_pkg::PEE_OP_DISARM ? cur_ff.step == 3'h5 : cur_ff.step == 3'h2) begin
            if (cur_ff.op == pee_pkg::PEE_OP_WRITE) begin
              nxt_ff.st = H_DATA;
              nxt_ff.go = 1'b1;
            end else begin
              nxt_ff.cnt = 21'(pee_pkg::PROGRAM_PERIOD_CYC);
              nxt_ff.st = H_GAP;
              nxt_ff.left = 7'h00;
            end
          end else begin
            nxt_ff.go = 1'b1;
          end
        end
      end
      H_DATA: begin
        if (cyc_done) begin
          if (cur_ff.op == pee_pkg::PEE_OP_READ) begin
            nxt_ff.rd = cyc_rdata;
            nxt_ff.st = H_FIN;
          end else begin
            nxt_ff.take = 1'b1;
            nxt_ff.last = wr_data;
            nxt_ff.cnt = 21'(LOAD_GAP_CYC);
            nxt_ff.st = H_GAP;
          end
        end
      end
      H_GAP: begin
        // Loads spaced well inside the window; arm and disarm sit out a full period
        if (cur_ff.cnt != 21'h0) begin
          nxt_ff.cnt = cur_ff.cnt - 21'h1;
        end else if (cur_ff.op != pee_pkg::PEE_OP_WRITE) begin
          nxt_ff.st = H_FIN;
        end else if (cur_ff.left != 7'h00) begin
          nxt_ff.left = cur_ff.left - 7'h01;
          // Offset wraps within the page; page bits never change
          nxt_ff.addr = {cur_ff.addr[12:6], 6'(cur_ff.addr[5:0] + 6'h01)};
          nxt_ff.st = H_DATA;
          nxt_ff.go = 1'b1;
        end else begin
          // Last load placed: polling lets the device start programming
          nxt_ff.st = H_POLL;
          nxt_ff.cnt = 21'(POLL_LIMIT);
          nxt_ff.go = 1'b1;
        end
      end
      H_POLL: begin
        // Toggle polling: two equal bit 6 reads, with bit 7 matching the last byte loaded, mean programming ended
        if (cyc_done) begin
          nxt_ff.have_prev = 1'b1;
          nxt_ff.prev6 = cyc_rdata[6];
          if ((cur_ff.have_prev && cyc_rdata[6] == cur_ff.prev6 &&
               cyc_rdata[7] == cur_ff.last[7]) || cur_ff.cnt == 21'h0) begin
            nxt_ff.tmo = cur_ff.cnt == 21'h0;
            nxt_ff.st = H_FIN;
          end else begin
            nxt_ff.cnt = cur_ff.cnt - 21'h1;
            nxt_ff.go = 1'b1;
          end
        end
      end
      H_FIN: begin
        nxt_ff.busy = 1'b0;
        nxt_ff.done = 1'b1;
        nxt_ff.st = H_IDLE;
      end
      default: nxt_ff.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{st: H_IDLE, op: pee_pkg::PEE_OP_READ, step: 3'h0, left: 7'h00,
                  addr: 13'h0000, last: 8'h00, cnt: 21'h0, go: 1'b0, take: 1'b0,
                  busy: 1'b0, done: 1'b0, tmo: 1'b0, rd: 8'h00, have_prev: 1'b0,
                  prev6: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign wr_data_take = cur_ff.take;
  assign busy = cur_ff.busy;
  assign done = cur_ff.done;
  assign timeout = cur_ff.tmo;
  assign rd_data = cur_ff.rd;
endmodule : pee_host

//--- bench/pee_host_checker.sv
// Pin and handshake assertions for the EEPROM host controller.
// Assumes it is bound to pee_host and sees its ports only.
`timescale 1ns/10ps
module pee_host_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User side
  input wire logic req_valid,
  input wire logic busy,
  input wire logic done,
  input wire logic timeout,
  input wire logic wr_data_take,
  // Device pins
  input wire logic [12:0] word_select_lines,
  input wire logic [7:0] byte_lines_o,
  input wire logic byte_lines_oe,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic wr_strobe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Pin levels; a clash would corrupt both drivers on the byte lines
  AST_RD_SEL: assert property (!out_gate_n |-> !chip_sel_n)
    else $error("gate low without select");
  AST_NO_CLASH: assert property (byte_lines_oe |-> out_gate_n)
    else $error("host drives while gate low");
  AST_WR_LVL: assert property (!wr_strobe_n |-> !chip_sel_n && out_gate_n)
    else $error("strobe low with wrong levels");
  // Address and data must not move while the device may latch them
  AST_WR_HOLD: assert property (!wr_strobe_n && !$past(wr_strobe_n) |->
    $stable(word_select_lines) && $stable(byte_lines_o) && byte_lines_oe)
    else $error("write pins moved in strobe");
  AST_WR_WIDTH: assert property ($fell(wr_strobe_n) |-> !wr_strobe_n[*5] ##1 wr_strobe_n)
    else $error("strobe width wrong");
  AST_RD_WIDTH: assert property ($fell(out_gate_n) |->
    !out_gate_n[*8] ##1 !out_gate_n ##1 out_gate_n)
    else $error("gate width wrong");
  AST_IDLE: assert property (!busy && !done |-> chip_sel_n && wr_strobe_n && out_gate_n)
    else $error("pins active while idle");
  AST_START: assert property (req_valid && !busy && !done |=> busy ##[1:40] !chip_sel_n)
    else $error("request not started");
  AST_DONE: assert property (done |=> !done && !busy)
    else $error("done not a single pulse");
  AST_TAKE: assert property (wr_data_take |-> busy && wr_strobe_n)
    else $error("take outside a write");
  // Main scenarios reached
  cover property (done && timeout);
  cover property ($fell(wr_strobe_n));
  cover property ($fell(out_gate_n));
endmodule : pee_host_checker

bind pee_host pee_host_checker pee_host_checker_i (
  .clk(clk), .rst(rst), .req_valid(req_valid), .busy(busy), .done(done),
  .timeout(timeout), .wr_data_take(wr_data_take), .word_select_lines(word_select_lines),
  .byte_lines_o(byte_lines_o), .byte_lines_oe(byte_lines_oe), .chip_sel_n(chip_sel_n),
  .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n)
);

//--- bench/pee_dev_model.sv
// Behavioural model of the byte-alterable EEPROM on the host pins.
// Assumes registered host pins; clk samples them and measures load window and program time.
`timescale 1ns/10ps
module pee_dev_model #(
  parameter int LOAD_CYC = 10000,
  parameter int PROG_CYC = 200000
) (
  // Timing clock
  input wire logic clk,
  // Pins from the host
  input wire logic [12:0] word_select_lines,
  input wire logic [7:0] byte_lines_o,
  input wire logic byte_lines_oe,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic wr_strobe_n,
  // Pins to the host
  output logic [7:0] byte_lines_i
);
  localparam logic [20:0] C0 = {pee_pkg::CMD_ADDR0, pee_pkg::CMD_DATA0};
  localparam logic [20:0] C1 = {pee_pkg::CMD_ADDR1, pee_pkg::CMD_DATA1};
  logic [7:0] mem [8192];
  logic [20:0] q [$];
  logic armed = 1'b0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic wr_q = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] drv = 8'h00;
  logic [12:0] la = 13'h0000;
  logic [7:0] ld = 8'h00;
  int idle = 0;
  int prog = 0;
  wire wr = !chip_sel_n && !wr_strobe_n && out_gate_n;
  wire rd = !chip_sel_n && !out_gate_n;
  // Released lines show the inverse of the last driven byte, never a hold
  assign byte_lines_i = !rd ? ~drv : busy ? {~last[7], tog, last[5:0]} : mem[word_select_lines];
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'(i * 37 + 5);
  end
  // Ends a page load: command prefixes decide what is programmed
  task automatic commit();
    int s;
    s = 0;
    if (q.size() >= 6 && q[0] == C0 && q[1] == C1 && q[2] == {pee_pkg::CMD_ADDR0, pee_pkg::CMD_DIS0}
        && q[3] == C0 && q[4] == C1 && q[5] == {pee_pkg::CMD_ADDR0, pee_pkg::CMD_DIS1}) begin
      armed = 1'b0;
      q = {};
    end else if (q.size() >= 3 && q[0] == C0 && q[1] == C1 && q[2] == {pee_pkg::CMD_ADDR0, pee_pkg::CMD_ARM}) begin
      armed = 1'b1;
      s = 3;
    end else if (armed) begin
      q = {};
    end
    busy = q.size() > 0 || !armed;
    prog = 0;
    for (int i = s; i < q.size() && i < s + 64; i++) begin
      mem[q[i][20:8]] = q[i][7:0];
      last = q[i][7:0];
    end
    q = {};
  endtask : commit
  // Latching and self-timed programming
  always @(posedge clk) begin
    if (wr && !wr_q) la = word_select_lines;
    if (wr) ld = byte_lines_o;
    if (!wr && wr_q && !busy) begin
      q.push_back({la, ld});
      idle = 0;
    end
    if (rd && !rd_q && busy) tog = !tog;
    if (q.size() > 0 && !busy && (idle >= LOAD_CYC || (rd && !rd_q))) commit();
    idle = idle + 1;
    prog = prog + 1;
    if (prog >= PROG_CYC) busy = 1'b0;
    if (rd) drv = byte_lines_i;
    wr_q = wr;
    rd_q = rd;
  end
endmodule : pee_dev_model

//--- bench/pee_host_tb_top.sv
// Self-checking bench: host controller against the EEPROM model.
// Assumes short load gap and poll limit; a reference array tracks contents.
`timescale 1ns/10ps
module pee_host_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  pee_pkg::pee_op_t req_op = pee_pkg::PEE_OP_READ;
  logic [12:0] req_addr = 13'h0000;
  logic [6:0] req_len_m1 = 7'h00;
  logic protected_mode = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_data_take, busy, done, timeout, byte_lines_oe, chip_sel_n, out_gate_n, wr_strobe_n;
  logic [7:0] rd_data, byte_lines_o, byte_lines_i;
  logic [12:0] word_select_lines;
  logic [7:0] lfsr = 8'h52;
  logic [7:0] wq [$];
  int ref_mem [8192];
  int errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  pee_host #(.LOAD_GAP_CYC(10), .POLL_LIMIT(50)) pee_host_i (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_len_m1(req_len_m1),
    .protected_mode(protected_mode), .wr_data(wr_data), .wr_data_take(wr_data_take),
    .busy(busy), .done(done), .timeout(timeout), .rd_data(rd_data),
    .word_select_lines(word_select_lines), .byte_lines_o(byte_lines_o),
    .byte_lines_oe(byte_lines_oe), .byte_lines_i(byte_lines_i), .chip_sel_n(chip_sel_n),
    .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n));
  pee_dev_model #(.LOAD_CYC(100), .PROG_CYC(300)) pee_dev_model_i (.clk(clk),
    .word_select_lines(word_select_lines), .byte_lines_o(byte_lines_o),
    .byte_lines_oe(byte_lines_oe), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .wr_strobe_n(wr_strobe_n), .byte_lines_i(byte_lines_i));
  task automatic final_report();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Maximal 8-bit sequence; seeded by the declaration
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  // Stays within the page, as the device demands of a page load
  function automatic logic [12:0] pg(input logic [12:0] a, input int i);
    return {a[12:6], 6'(a[5:0] + 6'(i))};
  endfunction : pg
  // Issues one request; feeds bytes on each take; waits for done if asked
  task automatic run(input pee_pkg::pee_op_t op, input logic [12:0] a, input int n,
                     input logic pm, input logic wt);
    int k;
    k = 0;
    @(negedge clk);
    req_op = op;
    req_addr = a;
    req_len_m1 = 7'(n - 1);
    protected_mode = pm;
    wr_data = wq.size() > 0 ? wq[0] : 8'h00;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    while (wt && done !== 1'b1 && k < 20000) begin
      @(negedge clk);
      if (wr_data_take === 1'b1 && wq.size() > 0) void'(wq.pop_front());
      wr_data = wq.size() > 0 ? wq[0] : 8'h00;
      k++;
    end
    if (k >= 20000) begin
      errors++;
      final_report();
    end
  endtask : run
  task automatic rd_chk(input logic [12:0] a);
    run(pee_pkg::PEE_OP_READ, a, 1, 1'b0, 1'b1);
    check(rd_data, 8'(ref_mem[a]));
  endtask : rd_chk
  // Page write; bit 7 of each byte differs from the old contents
  task automatic wr_chk(input logic [12:0] a, input int n, input logic pm, input logic eff);
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      wq.push_back({~ref_mem[pg(a, i)][7], lfsr[6:0]});
      if (eff) ref_mem[pg(a, i)] = {~ref_mem[pg(a, i)][7], lfsr[6:0]};
    end
    run(pee_pkg::PEE_OP_WRITE, a, n, pm, 1'b1);
    check({7'h00, timeout}, {7'h00, !eff});
    for (int i = 0; i < n; i++) rd_chk(pg(a, i));
  endtask : wr_chk
  // Command sequence, then a reset while the controller waits out programming
  task automatic cmd_rst(input pee_pkg::pee_op_t op, input logic want);
    int k;
    k = 0;
    run(op, 13'h0000, 1, 1'b0, 1'b0);
    while (pee_dev_model_i.armed !== want && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000) begin
      errors++;
      final_report();
    end
    check({7'h00, busy}, 8'h01);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    while (pee_dev_model_i.busy && k < 6000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 6000) begin
      errors++;
      final_report();
    end
    check({7'h00, pee_dev_model_i.armed}, {7'h00, want});
  endtask : cmd_rst
  initial begin
    for (int i = 0; i < 8192; i++) ref_mem[i] = (i * 37 + 5) & 255;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check({5'h00, chip_sel_n, out_gate_n, wr_strobe_n}, 8'h07);
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      rd_chk({lfsr[4:0], lfsr});
    end
    wr_chk(13'h0FBE, 4, 1'b0, 1'b1);
    wr_chk({lfsr[4:0], lfsr}, 1, 1'b0, 1'b1);
    wr_chk(13'h1A40, 64, 1'b0, 1'b1);
    cmd_rst(pee_pkg::PEE_OP_ARM, 1'b1);
    wr_chk(13'h0123, 2, 1'b0, 1'b0);
    wr_chk(13'h0300, 3, 1'b1, 1'b1);
    check({7'h00, pee_dev_model_i.armed}, 8'h01);
    cmd_rst(pee_pkg::PEE_OP_DISARM, 1'b0);
    wr_chk(13'h0456, 1, 1'b0, 1'b1);
    final_report();
  end
endmodule : pee_host_tb_top
